// ==== meas_seq_pkg.sv ====
// Shared constants, register indices and carrier types for the measurement sequencer
package meas_seq_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_LSB_INT_VDD = 8'h03;
    localparam logic [7:0] IDX_LSB_EXT_AIN = 8'h04;
    localparam logic [7:0] IDX_VDD_MSB     = 8'h06;
    localparam logic [7:0] IDX_INT_MSB     = 8'h07;
    localparam logic [7:0] IDX_EXT_MSB     = 8'h08;
    localparam logic [7:0] IDX_AIN2_MSB    = 8'h09;
    localparam logic [7:0] IDX_AIN3_MSB    = 8'h0A;
    localparam logic [7:0] IDX_AIN4_MSB    = 8'h0B;
    localparam logic [7:0] IDX_CFG1        = 8'h18;
    localparam logic [7:0] IDX_CFG2        = 8'h19;
    localparam logic [7:0] IDX_INT_OFS     = 8'h1D;
    localparam int         IDX_LSB         = 2;
    localparam int         IDX_MSB         = 9;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         CFG1_MON_EN     = 0;
    localparam int         CFG1_PINS_AIN   = 2;
    localparam int         CFG1_DAC_REF    = 4;
    localparam int         CFG2_SEL_LSB    = 0;
    localparam int         CFG2_SEL_MSB    = 2;
    localparam int         CFG2_SINGLE     = 4;
    localparam int         CFG2_AVG_DIS    = 5;
    localparam logic [7:0] CFG1_RST        = 8'h00;
    localparam logic [7:0] CFG2_RST        = 8'h00;
    localparam logic [7:0] OFS_RST         = 8'h00;
    localparam logic [9:0] VALUE_RST       = 10'h000;

    // ------------------------------------------------------------------
    // Channels, result slots, averaging, supply scaling
    // ------------------------------------------------------------------
    typedef logic [2:0] ch_t;
    localparam ch_t        CH_VDD          = 3'h0;
    localparam ch_t        CH_INT          = 3'h1;
    localparam ch_t        CH_EXT          = 3'h2;
    localparam ch_t        CH_AIN1         = 3'h3;
    localparam ch_t        CH_AIN2         = 3'h4;
    localparam ch_t        CH_AIN3         = 3'h5;
    localparam ch_t        CH_AIN4         = 3'h6;
    localparam int         NUM_SLOTS       = 6;
    localparam logic [3:0] AVG_LAST        = 4'hF;
    localparam logic [3:0] ONE_LAST        = 4'h0;
    localparam int         AVG_SHIFT       = 4;
    localparam int         ACC_W           = 14;
    localparam logic [9:0] VDD_FULL_SCALE  = 10'h3FF;
    localparam int         VDD_LSB_UV_X1K  = 2226;
    localparam int         VDD_SCALE_X100  = 307;

    // ------------------------------------------------------------------
    // Bus answers and carriers
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

    typedef struct packed {
        logic start;
        logic abort;
        ch_t  channel;
    } adc_req_t;

    typedef struct packed {
        logic       done;
        logic [9:0] code;
    } adc_rsp_t;

    typedef enum logic {ST_IDLE = 1'b0, ST_CONV = 1'b1} seq_state_t;

endpackage

// ==== meas_seq.sv ====
// Measurement channel sequencer with AXI4-Lite register access
// Function
// - After reset: round-robin mode, monitoring off, no conversions.
// - Monitor enable bit set to 1 lets conversions start.
// - Round robin order: supply, internal temp, diode or inputs 1/2, input 3, input 4.
// - After input 4 completes, wrap to supply without software help.
// - Shared pins act as diode pair or two inputs, filling third slot.
// - Single-channel select bit in register 19h selects single-channel mode.
// - Single mode measures the channel in the three-bit select field.
// - Select field zero measures only the supply channel.
// - Select field one measures the internal temperature channel.
// - Single mode restarts conversions back to back.
// - Any bus access halts conversion; restart once access completes.
// - Supply code straight binary, 7 V reads full scale 3FF.
// - Converter always uses internal reference for supply and temperatures.
// - Reference amplifier powered only while monitoring is enabled.
// - DAC outputs default to external reference pin after reset.
// - Temperature results are 10-bit twos complement.
// - Internal temperature offset added before storing result.
// - Temperature results average 16 successive conversions.
// - Each channel's value register updates when its conversion completes.
// - Averaging disable at bit 5 of register 19h, averaging on by default.
// - Supply low two bits at 03h, upper eight bits at 06h.
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module meas_seq
    import meas_seq_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output adc_req_t         adcReq,
    input  wire adc_rsp_t    adcRsp,
    output logic             refAmpOn,
    output logic             adcRefInternal,
    output logic             dacRefInternal
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                    awready_r;
    logic                    wready_r;
    logic                    bvalid_r;
    logic [1:0]              bresp_r;
    logic                    arready_r;
    logic                    rvalid_r;
    logic [1:0]              rresp_r;
    logic [31:0]             rdata_r;
    logic [7:0]              wIdx_r;
    logic [7:0]              wByte_r;
    logic                    wLane_r;
    logic [7:0]              cfg1_r;
    logic [7:0]              cfg2_r;
    logic [7:0]              intOfs_r;
    logic [9:0]              value_r [NUM_SLOTS];
    seq_state_t              state_r;
    ch_t                     chan_r;
    logic [3:0]              cnt_r;
    logic signed [ACC_W-1:0] acc_r;
    adc_req_t                adcReq_r;
    logic                    refAmpOn_r;
    logic                    adcRefInt_r;
    logic                    dacRefInt_r;

    // ------------------------------------------------------------------
    // Write channel: address and data taken in either order
    // ------------------------------------------------------------------
    wire       awTake    = awvalid && awready_r;
    wire       wTake     = wvalid && wready_r;
    wire       doWrite   = !awready_r && !wready_r && !bvalid_r;
    wire       bDone     = bvalid_r && bready;
    wire [7:0] awIdxIn   = awaddr[IDX_MSB:IDX_LSB];
    wire       wrCfg1    = doWrite && wLane_r && (wIdx_r == IDX_CFG1);
    wire       wrCfg2    = doWrite && wLane_r && (wIdx_r == IDX_CFG2);
    wire       wrOfs     = doWrite && wLane_r && (wIdx_r == IDX_INT_OFS);
    wire       wMapped   = (wIdx_r == IDX_CFG1) || (wIdx_r == IDX_CFG2) || (wIdx_r == IDX_INT_OFS);

    // Handshake flags for the write path
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            if (awTake) awready_r <= 1'b0;
            if (wTake) wready_r <= 1'b0;
            if (doWrite) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wMapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (bDone) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // Captured write address and low data byte
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wIdx_r  <= 8'h00;
            wByte_r <= 8'h00;
            wLane_r <= 1'b0;
        end else begin
            if (awTake) wIdx_r <= awIdxIn;
            if (wTake) wByte_r <= wdata[7:0];
            if (wTake) wLane_r <= wstrb[0];
        end
    end

    // Configuration registers; monitoring off and round robin after reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg1_r   <= CFG1_RST;
            cfg2_r   <= CFG2_RST;
            intOfs_r <= OFS_RST;
        end else begin
            if (wrCfg1) cfg1_r <= wByte_r;
            if (wrCfg2) cfg2_r <= wByte_r;
            if (wrOfs) intOfs_r <= wByte_r;
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    wire       arTake  = arvalid && arready_r;
    wire       rDone   = rvalid_r && rready;
    wire [7:0] rIdx    = araddr[IDX_MSB:IDX_LSB];
    wire [7:0] lsbA    = {4'h0, value_r[1][1:0], value_r[0][1:0]};
    wire [7:0] lsbB    = {value_r[5][1:0], value_r[4][1:0], value_r[3][1:0], value_r[2][1:0]};
    wire       hitLsbA = rIdx == IDX_LSB_INT_VDD;
    wire       hitLsbB = rIdx == IDX_LSB_EXT_AIN;
    wire       hitVdd  = rIdx == IDX_VDD_MSB;
    wire       hitInt  = rIdx == IDX_INT_MSB;
    wire       hitExt  = rIdx == IDX_EXT_MSB;
    wire       hitAin2 = rIdx == IDX_AIN2_MSB;
    wire       hitAin3 = rIdx == IDX_AIN3_MSB;
    wire       hitAin4 = rIdx == IDX_AIN4_MSB;
    wire       hitCfg1 = rIdx == IDX_CFG1;
    wire       hitCfg2 = rIdx == IDX_CFG2;
    wire       hitOfs  = rIdx == IDX_INT_OFS;
    wire       rMapped = hitLsbA || hitLsbB || hitVdd || hitInt || hitExt || hitAin2 || hitAin3 || hitAin4
                         || hitCfg1 || hitCfg2 || hitOfs;
    wire [7:0] rByte   = hitLsbA ? lsbA :
                         hitLsbB ? lsbB :
                         hitVdd  ? value_r[0][9:2] :
                         hitInt  ? value_r[1][9:2] :
                         hitExt  ? value_r[2][9:2] :
                         hitAin2 ? value_r[3][9:2] :
                         hitAin3 ? value_r[4][9:2] :
                         hitAin4 ? value_r[5][9:2] :
                         hitCfg1 ? cfg1_r :
                         hitCfg2 ? cfg2_r :
                         hitOfs  ? intOfs_r : 8'h00;

    // Read answer one cycle after the address is taken
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
        end else if (arTake) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rresp_r   <= rMapped ? RESP_OKAY : RESP_SLVERR;
            rdata_r   <= {24'h00_0000, rByte};
        end else if (rDone) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer decode
    // ------------------------------------------------------------------
    // Any transaction that is offered or not yet answered halts conversion
    wire busAccess = awvalid || wvalid || arvalid || !awready_r || !wready_r || !arready_r;
    wire monEn     = cfg1_r[CFG1_MON_EN];
    wire pinsAin   = cfg1_r[CFG1_PINS_AIN];
    wire single    = cfg2_r[CFG2_SINGLE];
    wire avgOn     = !cfg2_r[CFG2_AVG_DIS];
    wire [2:0] sel = cfg2_r[CFG2_SEL_MSB:CFG2_SEL_LSB];

    // Channel chosen by the select field; the third code follows the pin use
    wire ch_t selCh = (sel == 3'h0) ? CH_VDD :
                      (sel == 3'h1) ? CH_INT :
                      (sel == 3'h2) ? (pinsAin ? CH_AIN1 : CH_EXT) :
                      (sel == 3'h3) ? CH_AIN2 :
                      (sel == 3'h4) ? CH_AIN3 :
                      (sel == 3'h5) ? CH_AIN4 : CH_VDD;

    // Fixed round robin order with the shared slot set by the pin use
    wire ch_t rrNext = (chan_r == CH_VDD)  ? CH_INT :
                       (chan_r == CH_INT)  ? (pinsAin ? CH_AIN1 : CH_EXT) :
                       (chan_r == CH_EXT)  ? CH_AIN3 :
                       (chan_r == CH_AIN1) ? CH_AIN2 :
                       (chan_r == CH_AIN2) ? CH_AIN3 :
                       (chan_r == CH_AIN3) ? CH_AIN4 : CH_VDD;

    // Conversion completion, averaging and result shaping
    wire                    inConv   = state_r == ST_CONV;
    wire                    abortNow = inConv && (busAccess || !monEn);
    wire                    gotDone  = inConv && adcRsp.done && !abortNow;
    wire                    isTemp   = (chan_r == CH_INT) || (chan_r == CH_EXT);
    wire                    useAvg   = isTemp && avgOn;
    wire [3:0]              lastCnt  = useAvg ? AVG_LAST : ONE_LAST;
    wire                    lastSmp  = cnt_r == lastCnt;
    wire                    storeNow = gotDone && lastSmp;
    wire signed [ACC_W-1:0] codeExt  = {{(ACC_W-10){adcRsp.code[9]}}, adcRsp.code};
    wire signed [ACC_W-1:0] accNxt   = ((cnt_r == ONE_LAST) ? '0 : acc_r) + codeExt;
    wire [9:0]              avgCode  = accNxt[AVG_SHIFT+9:AVG_SHIFT];
    wire [9:0]              tempCode = useAvg ? avgCode : adcRsp.code;
    wire [9:0]              ofsExt   = {{2{intOfs_r[7]}}, intOfs_r};
    wire [9:0]              intCode  = tempCode + ofsExt;
    // Supply code arrives pre-scaled by 3.07 onto the 2.28 V range: straight binary, 3FF at 7 V
    wire [9:0]              result   = (chan_r == CH_INT) ? intCode :
                                       isTemp ? tempCode : adcRsp.code;
    wire                    idleGo   = (state_r == ST_IDLE) && monEn && !busAccess;
    wire                    startNow = idleGo || gotDone;
    // Mode and select are re-read at every start, back-to-back restarts included
    wire ch_t               startCh  = single ? selCh :
                                       (idleGo ? chan_r : (lastSmp ? rrNext : chan_r));
    wire [2:0]              slot     = (chan_r == CH_AIN1) ? 3'h2 :
                                       (chan_r > CH_AIN1) ? 3'(chan_r - 3'h1) : chan_r;

    // ------------------------------------------------------------------
    // Sequencer state, sample counter and accumulator
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            chan_r  <= CH_VDD;
            cnt_r   <= ONE_LAST;
            acc_r   <= '0;
        end else if (abortNow) begin
            state_r <= ST_IDLE;
            cnt_r   <= ONE_LAST;
        end else if (startNow) begin
            state_r <= ST_CONV;
            chan_r  <= startCh;
            cnt_r   <= (gotDone && !lastSmp) ? cnt_r + 4'h1 : ONE_LAST;
            acc_r   <= accNxt;
        end
    end

    // Request to the converter: one-cycle start or abort pulses
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            adcReq_r <= '0;
        end else begin
            adcReq_r.start <= startNow && !abortNow;
            adcReq_r.abort <= abortNow;
            if (startNow && !abortNow) adcReq_r.channel <= startCh;
        end
    end

    // Reference controls
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            refAmpOn_r  <= 1'b0;
            adcRefInt_r <= 1'b1;
            dacRefInt_r <= 1'b0;
        end else begin
            refAmpOn_r  <= monEn;
            adcRefInt_r <= 1'b1;
            dacRefInt_r <= cfg1_r[CFG1_DAC_REF];
        end
    end

    // Value registers, one per result slot
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOTS; gi++) begin : gSlot
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) value_r[gi] <= VALUE_RST;
                else if (storeNow && (slot == 3'(gi))) value_r[gi] <= result;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign awready        = awready_r;
    assign wready         = wready_r;
    assign bvalid         = bvalid_r;
    assign bresp          = bresp_r;
    assign arready        = arready_r;
    assign rvalid         = rvalid_r;
    assign rresp          = rresp_r;
    assign rdata          = rdata_r;
    assign adcReq         = adcReq_r;
    assign refAmpOn       = refAmpOn_r;
    assign adcRefInternal = adcRefInt_r;
    assign dacRefInternal = dacRefInt_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_quietEnable;
        monEn && !busAccess && (state_r == ST_IDLE);
    endsequence

    sequence s_lastStore;
        storeNow && !single && (chan_r == CH_AIN4);
    endsequence

    sequence s_intStore;
        storeNow && !single && (chan_r == CH_INT);
    endsequence

    // Dones taken since the last store or halt, counted apart from the sequencer counter
    logic [4:0] doneSeen_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            doneSeen_r <= '0;
        end else if (abortNow || storeNow) begin
            doneSeen_r <= '0;
        end else if (gotDone) begin
            doneSeen_r <= doneSeen_r + 5'h01;
        end
    end

    a_no_start_off: assert property (adcReq_r.start |-> $past(monEn))
        else $error("conversion started with monitoring off");
    a_enable_start: assert property (s_quietEnable |=> adcReq_r.start && inConv)
        else $error("enable did not start a conversion");
    a_rr_wrap: assert property (s_lastStore |=> adcReq_r.channel == CH_VDD)
        else $error("round robin did not wrap to supply");
    a_rr_order: assert property (storeNow && !single && chan_r == CH_VDD |=> adcReq_r.channel == CH_INT)
        else $error("round robin order broken");
    a_single_chan: assert property (adcReq_r.start && $past(single && sel == 3'h0) |-> adcReq_r.channel == CH_VDD)
        else $error("single mode did not pick supply");
    a_back_back: assert property (gotDone |=> adcReq_r.start)
        else $error("no back to back restart");
    a_halt_abort: assert property (inConv && busAccess |=> adcReq_r.abort && !adcReq_r.start ##1 !inConv)
        else $error("bus access did not halt conversion");
    a_amp_power: assert property (!monEn [*2] |-> !refAmpOn_r)
        else $error("reference amplifier on while disabled");
    a_avg_count: assert property (storeNow && useAvg |-> doneSeen_r == 5'(AVG_LAST))
        else $error("average stored before sixteen samples");
    a_one_sample: assert property (storeNow && !useAvg |-> doneSeen_r == 5'h00)
        else $error("single result stored after extra samples");
    a_rr_third: assert property (s_intStore |=> adcReq_r.channel == ($past(pinsAin) ? CH_AIN1 : CH_EXT))
        else $error("third slot does not follow pin use");
    a_amp_on: assert property (monEn [*2] |-> refAmpOn_r)
        else $error("reference amplifier off while enabled");
    a_int_store: assert property (storeNow && chan_r == CH_INT |=> value_r[1] == $past(intCode))
        else $error("internal result not stored with offset");

endmodule

// ==== adc_model.sv ====
// Behavioural converter model facing the sequencer
`timescale 1ns/100ps
module adc_model
    import meas_seq_pkg::*;
(
    input  wire logic     clock,
    input  wire logic     rst_n,
    input  wire adc_req_t adcReq,
    input  wire logic     slow,
    output adc_rsp_t      adcRsp
);
    logic       busy_r;
    logic [3:0] cnt_r;
    ch_t        ch_r;
    logic [9:0] last_r;
    // Fixed code per channel; internal reads minus two
    wire  [9:0] codeOut = (ch_r == CH_VDD) ? 10'h3FF : (ch_r == CH_INT) ? 10'h3FE : {4'h0, ch_r, 3'h5};

    // Conversion timer; code lines show garbage outside the done pulse
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            cnt_r  <= 4'h0;
            ch_r   <= 3'h0;
            last_r <= 10'h000;
            adcRsp <= '0;
        end else begin
            adcRsp <= {1'b0, ~last_r};
            if (adcReq.abort) begin
                busy_r <= 1'b0;
            end else if (adcReq.start) begin
                busy_r <= 1'b1;
                ch_r   <= adcReq.channel;
                cnt_r  <= slow ? 4'h9 : 4'h1;
            end else if (busy_r && cnt_r == 4'h0) begin
                busy_r <= 1'b0;
                adcRsp <= {1'b1, codeOut};
                last_r <= codeOut;
            end else if (busy_r) begin
                cnt_r  <= cnt_r - 4'h1;
            end
        end
    end
endmodule

// ==== tb_meas_seq.sv ====
// Self-checking bench for the measurement sequencer
`timescale 1ns/100ps
module tb_meas_seq
    import meas_seq_pkg::*;
;
    logic clock, rst_n, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, slow = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, refAmpOn, adcRefInternal, dacRefInternal;
    logic [1:0] bresp, rresp, lastResp;
    logic [7:0] lastData;
    adc_req_t adcReq;
    adc_rsp_t adcRsp;
    int fails = 0, numChecks = 0, cyc = 0, aborts = 0, k;
    ch_t chLog[$];
    int runs[$];

    meas_seq meas_seq_i (.clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .adcReq(adcReq), .adcRsp(adcRsp), .refAmpOn(refAmpOn),
        .adcRefInternal(adcRefInternal), .dacRefInternal(dacRefInternal));
    adc_model adc_model_i (.clock(clock), .rst_n(rst_n), .adcReq(adcReq), .slow(slow), .adcRsp(adcRsp));

    // Clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Hang guard, start log and abort count
    always @(posedge clock) begin
        if (adcReq.abort === 1'b1)
            aborts++;
        if (adcReq.start === 1'b1 && (chLog.size() == 0 || chLog[$] !== adcReq.channel)) begin
            chLog.push_back(adcReq.channel);
            runs.push_back(1);
        end else if (adcReq.start === 1'b1)
            runs[$] += 1;
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test;
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        logic a, w;
        a = 1;
        w = 1;
        @(posedge clock);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (a || w) begin
            @(posedge clock);
            if (a && awready === 1'b1) begin
                a = 0;
                awvalid <= 0;
            end
            if (w && wready === 1'b1) begin
                w = 0;
                wvalid <= 0;
            end
        end
        do @(posedge clock); while (bvalid !== 1'b1);
        lastResp = bresp;
        bready <= 0;
    endtask
    task automatic rreg(input logic [7:0] idx);
        @(posedge clock);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1;
        rready <= 1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge clock); while (rvalid !== 1'b1);
        lastData = rdata[7:0];
        lastResp = rresp;
        rready <= 0;
    endtask
    // Clears the log, waits for twelve logged channel runs, compares from the first supply start
    task automatic chkRound(input ch_t e[6], input int nAvg);
        chLog.delete();
        runs.delete();
        for (int i = 0; i < 3000 && chLog.size() < 12; i++) @(posedge clock);
        for (k = 0; k < 5 && chLog[k] !== CH_VDD; k++);
        foreach (e[i]) chk("round order", 32'(chLog[k + i]), 32'(e[i]));
        chk("averaged run", runs[k + 1], nAvg);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk("ref amp", refAmpOn, 0);
        chk("adc ref", adcRefInternal, 1);
        chk("dac ref", dacRefInternal, 0);
        rreg(IDX_CFG2);
        chk("cfg2 default", lastData, 8'h00);
        repeat (20) @(posedge clock);
        chk("idle starts", chLog.size(), 0);
        $display("test reset done");
    endtask
    task automatic t_round;
        wreg(IDX_INT_OFS, 8'h05);
        wreg(IDX_CFG1, 8'h01);
        @(posedge clock);
        chk("ref amp on", refAmpOn, 1);
        chkRound('{CH_VDD, CH_INT, CH_EXT, CH_AIN3, CH_AIN4, CH_VDD}, 16);
        rreg(IDX_VDD_MSB);
        chk("supply msb", lastData, 8'hFF);
        rreg(IDX_LSB_INT_VDD);
        chk("shared lsb", lastData, 8'h0F);
        rreg(IDX_INT_MSB);
        chk("internal msb", lastData, 8'h00);
        rreg(IDX_EXT_MSB);
        chk("diode msb", lastData, 8'h05);
        rreg(8'h30);
        chk("unmapped read", lastResp, RESP_SLVERR);
        wreg(IDX_VDD_MSB, 8'h00);
        chk("read-only write", lastResp, RESP_SLVERR);
        $display("test round robin done");
    endtask
    task automatic t_pins;
        wreg(IDX_CFG2, 8'h20);
        wreg(IDX_CFG1, 8'h05);
        chkRound('{CH_VDD, CH_INT, CH_AIN1, CH_AIN2, CH_AIN3, CH_AIN4}, 1);
        $display("test input pins done");
    endtask
    task automatic t_single;
        logic [7:0] cfg[4] = '{8'h10, 8'h11, 8'h14, 8'h32};
        ch_t exp[4] = '{CH_VDD, CH_INT, CH_AIN3, CH_AIN1};
        slow <= 1;
        foreach (cfg[i]) begin
            wreg(IDX_CFG2, cfg[i]);
            chLog.delete();
            runs.delete();
            repeat (100) @(posedge clock);
            chk("single count", chLog.size(), 1);
            chk("single channel", 32'(chLog[0]), 32'(exp[i]));
            chk("back to back", runs[0] > 2, 1);
        end
        $display("test single done");
    endtask
    task automatic t_halt;
        aborts = 0;
        rreg(IDX_CFG1);
        chk("cfg1 readback", lastData, 8'h05);
        rreg(IDX_EXT_MSB);
        chk("input1 msb", lastData, 8'h07);
        chk("aborted", aborts > 0, 1);
        chLog.delete();
        repeat (30) @(posedge clock);
        chk("restart", 32'(chLog[0]), 32'(CH_AIN1));
        $display("test halt done");
    endtask
    task automatic t_off;
        wreg(IDX_CFG1, 8'h10);
        @(posedge clock);
        chk("ref amp off", refAmpOn, 0);
        chk("dac ref on", dacRefInternal, 1);
        chLog.delete();
        repeat (50) @(posedge clock);
        chk("stopped", chLog.size(), 0);
        $display("test off done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        t_reset;
        t_round;
        t_pins;
        t_single;
        t_halt;
        t_off;
        finish_test;
    end
endmodule
